// [pmas_pkg.sv]
// Shared constants for the PHY extended access and status register bank.
package pmas_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_FLD_MODE    = 6'h0c;
    localparam logic [5:0] IDX_ACC_CTRL    = 6'h0d;
    localparam logic [5:0] IDX_WINDOW      = 6'h0e;
    localparam logic [5:0] IDX_FLD_STAT    = 6'h0f;
    localparam logic [5:0] IDX_PHY_STAT    = 6'h10;
    localparam logic [5:0] IDX_RX_ERR_CNT  = 6'h15;
    localparam logic [5:0] IDX_TENBASE     = 6'h1a;

    // Reset values.
    localparam logic [15:0] ACC_CTRL_RESET = 16'h0000;
    localparam logic [15:0] WINDOW_RESET   = 16'h0010;
    localparam logic [15:0] FLD_MODE_RESET = 16'h0000;

    // Writable masks.
    localparam logic [15:0] ACC_CTRL_MASK  = 16'hc01f;
    localparam logic [15:0] FLD_MODE_MASK  = 16'h040f;

    // Field positions.
    localparam int CMD_HI          = 15;
    localparam int CMD_LO          = 14;
    localparam int DEVSEL_HI       = 4;
    localparam int CAUSE_LO        = 4;
    localparam int CAUSE_W         = 5;
    localparam int FLD_EN_DESCR    = 10;
    localparam int FLD_EN_LOW_HI   = 3;
    localparam int STAT_MDIX_BIT   = 14;
    localparam int STAT_RXERR_BIT  = 13;
    localparam int STAT_POL_BIT    = 12;
    localparam int TENBASE_POL_BIT = 4;

    // Window command encodings.
    localparam logic [1:0] CMD_ADDRESS   = 2'h0;
    localparam logic [1:0] CMD_DATA_NOINC = 2'h1;
    localparam logic [1:0] CMD_DATA_INC_RW = 2'h2;
    localparam logic [1:0] CMD_DATA_INC_W  = 2'h3;

    // Device-select values.
    localparam logic [4:0] DEVSEL_VENDOR = 5'h1f;
    localparam logic [4:0] DEVSEL_MMD3   = 5'h03;
    localparam logic [4:0] DEVSEL_MMD7   = 5'h07;

    // Highest vendor-space register offset.
    localparam logic [15:0] VENDOR_MAX = 16'h04d1;

    // Space codes used as the top bits of the backing memory address.
    localparam logic [1:0] SPACE_VENDOR = 2'h0;
    localparam logic [1:0] SPACE_MMD3   = 2'h1;
    localparam logic [1:0] SPACE_MMD7   = 2'h2;

    // Bus access state.
    typedef enum logic [1:0] {
        PMAS_IDLE,
        PMAS_MEM_WAIT,
        PMAS_ACK
    } pmas_bus_e;

endpackage

// [pmas_mem.sv]
// Backing store for the three reachable MMD register spaces, registered read data.
`timescale 1ns/1ps
module pmas_mem #(
    parameter int AW = 13
) (
    input  wire logic          CLOCK,
    input  wire logic          we,
    input  wire logic [1:0]    wbe,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [15:0]   wdata,
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [15:0]   rdata_q
);

    logic [15:0] mem [0:(1<<AW)-1];

    // Per-lane writes so a half-word bus write leaves the other lane intact.
    always_ff @(posedge CLOCK) begin
        if (we && wbe[0]) begin
            mem[waddr][7:0] <= wdata[7:0];
        end
        if (we && wbe[1]) begin
            mem[waddr][15:8] <= wdata[15:8];
        end
    end

    // Read data leaves from a register, one cycle after the request.
    always_ff @(posedge CLOCK) begin
        if (re) begin
            rdata_q <= mem[raddr];
        end
    end

endmodule

// [pmas_top.sv]
// Extended MMD access window, link-drop cause latches and PHY status summary bits.
//
// Function
// - The five-bit device select in the access control register picks the MMD for window access.
// - Device select all ones reaches the vendor space, offsets up to 0x04d1 only.
// - Device select 00011 reaches MMD3 and 00111 reaches MMD7.
// - Window accesses under any other device select are ignored with no side effect.
// - Command 00 makes the window the MMD address register; other commands make it data.
// - Command 01 keeps the address, 10 increments after reads and writes, 11 after writes only.
// - Each link-drop cause bit latches high when its enabled condition drops the link.
// - Cause bits are descrambler 8, receive errors 7, MLT3 6, SNR 5, energy loss 4.
// - The link drops on the OR of all enabled conditions, in any combination.
// - Status bit 14 reads 1 when the pairs are swapped and 0 when they are normal.
// - The receive error latch sets on any receive error and clears on a counter read.
// - The polarity bit mirrors the 10 Mb/s status latch, cleared by that read only.
`timescale 1ns/1ps
module pmas_top
    import pmas_pkg::*;
#(
    parameter int MMD_AW = 11
) (
    input  wire logic                      CLOCK,
    input  wire logic                      RESET_N,
    input  wire logic [7:0]                ADDRESS,
    input  wire logic                      READ,
    input  wire logic                      WRITE,
    input  wire logic [31:0]               WRITEDATA,
    input  wire logic [3:0]                BYTEENABLE,
    output logic      [31:0]               READDATA,
    output logic                           WAITREQUEST,
    input  wire logic [pmas_pkg::CAUSE_W-1:0] FLD_COND,
    input  wire logic                      RX_ERR_EVT,
    input  wire logic                      MDIX_SWAPPED,
    input  wire logic                      POLARITY_INV,
    output logic                           LINK_DROP
);
    import pmas_pkg::*;

    // Refuse spaces too small to hold the vendor range.
    if (MMD_AW < 11) begin : g_aw_check
        $error("pmas_top: MMD_AW must be at least 11");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    localparam int SW = CAUSE_W + 3;
    logic [SW-1:0] sync1_q;
    logic [SW-1:0] sync2_q;
    logic          rx_err_d3_q;
    logic [CAUSE_W-1:0] cond_s;
    logic          rx_err_s;
    logic          mdix_s;
    logic          pol_s;

    // Two flops on every pin; the second stage feeds logic, and the receive error pin adds a third flop for its edge detect.
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            sync1_q     <= '0;
            sync2_q     <= '0;
            rx_err_d3_q <= 1'b0;
        end else begin
            sync1_q     <= {POLARITY_INV, MDIX_SWAPPED, RX_ERR_EVT, FLD_COND};
            sync2_q     <= sync1_q;
            rx_err_d3_q <= sync2_q[CAUSE_W];
        end
    end

    assign cond_s   = sync2_q[CAUSE_W-1:0];
    assign rx_err_s = sync2_q[CAUSE_W] & ~rx_err_d3_q; // One event per error pulse.
    assign mdix_s   = sync2_q[CAUSE_W+1];
    assign pol_s    = sync2_q[CAUSE_W+2];

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode and handshake.

    pmas_bus_e   state_q;
    pmas_bus_e   state_d;
    logic [5:0]  idx;
    logic [15:0] wmask;
    logic [15:0] wdat;
    logic        rd_go;
    logic        wr_go;
    logic        rd_win;
    logic        wr_win;

    assign idx   = ADDRESS[7:2];
    assign wmask = {{8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};
    assign wdat  = WRITEDATA[15:0];
    assign rd_go = READ & (state_q == PMAS_IDLE);
    assign wr_go = WRITE & (state_q == PMAS_IDLE);
    assign rd_win = rd_go & (idx == IDX_WINDOW);
    assign wr_win = wr_go & (idx == IDX_WINDOW);

    ////////////////////////////////////////////////////////////////////////////////
    // Extended access control and per-space address registers.

    logic [15:0] acc_q;
    logic [1:0]  cmd;
    logic [4:0]  devsel;
    logic        supported;
    logic [1:0]  space;
    logic [15:0] mmd_addr_q [0:2];
    logic [15:0] cur_addr;
    logic        in_range;
    logic        data_cmd;
    logic        step_addr;

    assign cmd    = acc_q[CMD_HI:CMD_LO];
    assign devsel = acc_q[DEVSEL_HI:0];
    assign data_cmd = (cmd != CMD_ADDRESS);

    // Map the device select onto a backing space.
    always_comb begin
        supported = 1'b1;
        space     = SPACE_VENDOR;
        if (devsel == DEVSEL_VENDOR) begin
            space = SPACE_VENDOR;
        end else if (devsel == DEVSEL_MMD3) begin
            space = SPACE_MMD3;
        end else if (devsel == DEVSEL_MMD7) begin
            space = SPACE_MMD7;
        end else begin
            supported = 1'b0;
        end
    end

    assign cur_addr = mmd_addr_q[space];
    // Vendor space stops at its top offset; the others at the store size.
    assign in_range = (space == SPACE_VENDOR) ? (cur_addr <= VENDOR_MAX)
                                              : (cur_addr[15:MMD_AW] == '0);

    // Control register write.
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            acc_q <= ACC_CTRL_RESET;
        end else if (wr_go && idx == IDX_ACC_CTRL) begin
            acc_q <= (acc_q & ~(wmask & ACC_CTRL_MASK)) | (wdat & wmask & ACC_CTRL_MASK);
        end
    end

    // Data writes under either increment command step the address; data reads step it only under command 10.
    always_comb begin
        step_addr = 1'b0;
        if (supported && data_cmd) begin
            if (wr_win) begin
                step_addr = (cmd == CMD_DATA_INC_RW) || (cmd == CMD_DATA_INC_W);
            end else if (rd_win) begin
                step_addr = (cmd == CMD_DATA_INC_RW);
            end
        end
    end

    // One address register per space, so switching spaces keeps each pointer.
    for (genvar s = 0; s < 3; s++) begin : g_addr
        always_ff @(posedge CLOCK) begin
            if (!RESET_N) begin
                mmd_addr_q[s] <= WINDOW_RESET;
            end else if (supported && space == 2'(s)) begin
                if (wr_win && !data_cmd) begin
                    mmd_addr_q[s] <= (mmd_addr_q[s] & ~wmask) | (wdat & wmask);
                end else if (step_addr) begin
                    mmd_addr_q[s] <= mmd_addr_q[s] + 16'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Backing store for window data.

    logic              mem_we;
    logic              mem_re;
    logic [MMD_AW+1:0] mem_addr;
    logic [15:0]       mem_rdata;

    assign mem_addr = {space, cur_addr[MMD_AW-1:0]};
    assign mem_we   = wr_win & supported & data_cmd & in_range;
    assign mem_re   = rd_win & supported & data_cmd & in_range;

    pmas_mem #(
        .AW(MMD_AW + 2)
    ) u_mem (
        .CLOCK  (CLOCK),
        .we     (mem_we),
        .wbe    (BYTEENABLE[1:0]),
        .waddr  (mem_addr),
        .wdata  (wdat),
        .re     (mem_re),
        .raddr  (mem_addr),
        .rdata_q(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Fast link-down enables, cause latches and link drop.

    logic [15:0]        fld_mode_q;
    logic [CAUSE_W-1:0] fld_en;
    logic [CAUSE_W-1:0] fire;
    logic [CAUSE_W-1:0] cause_q;
    logic               clr_fld;
    logic               link_drop_q;

    // Enable register; writes touch only the mode bits.
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            fld_mode_q <= FLD_MODE_RESET;
        end else if (wr_go && idx == IDX_FLD_MODE) begin
            fld_mode_q <= (fld_mode_q & ~(wmask & FLD_MODE_MASK))
                        | (wdat & wmask & FLD_MODE_MASK);
        end
    end

    assign fld_en  = {fld_mode_q[FLD_EN_DESCR], fld_mode_q[FLD_EN_LOW_HI:0]};
    assign fire    = cond_s & fld_en;
    assign clr_fld = rd_go & (idx == IDX_FLD_STAT);

    // Each cause latches; a firing in the clearing cycle stays set.
    for (genvar i = 0; i < CAUSE_W; i++) begin : g_cause
        always_ff @(posedge CLOCK) begin
            if (!RESET_N) begin
                cause_q[i] <= 1'b0;
            end else if (fire[i]) begin
                cause_q[i] <= 1'b1;
            end else if (clr_fld) begin
                cause_q[i] <= 1'b0;
            end
        end
    end

    // Drop the link on any enabled condition.
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            link_drop_q <= 1'b0;
        end else begin
            link_drop_q <= |fire;
        end
    end

    assign LINK_DROP = link_drop_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Receive error latch and counter, polarity latch.

    logic        rx_latch_q;
    logic [15:0] rx_cnt_q;
    logic        pol_q;
    logic        clr_rx;
    logic        clr_pol;

    assign clr_rx  = rd_go & (idx == IDX_RX_ERR_CNT);
    assign clr_pol = rd_go & (idx == IDX_TENBASE);

    // The counter saturates rather than wrap, so a read never shows a small count.
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            rx_latch_q <= 1'b0;
            rx_cnt_q   <= 16'h0000;
        end else begin
            if (rx_err_s) begin
                rx_latch_q <= 1'b1;
            end else if (clr_rx) begin
                rx_latch_q <= 1'b0;
            end
            if (clr_rx) begin
                rx_cnt_q <= {15'h0000, rx_err_s};
            end else if (rx_err_s && rx_cnt_q != 16'hffff) begin
                rx_cnt_q <= rx_cnt_q + 16'h0001;
            end
        end
    end

    // Polarity latch; only the 10 Mb/s status read clears it.
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            pol_q <= 1'b0;
        end else if (pol_s) begin
            pol_q <= 1'b1;
        end else if (clr_pol) begin
            pol_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data and bus state.

    logic [15:0] rd_val;
    logic [31:0] readdata_q;

    // Register read mux; unmapped and reserved bits return zero.
    always_comb begin
        rd_val = 16'h0000;
        if (idx == IDX_FLD_MODE) begin
            rd_val = fld_mode_q;
        end else if (idx == IDX_ACC_CTRL) begin
            rd_val = acc_q;
        end else if (idx == IDX_WINDOW) begin
            rd_val = (supported && !data_cmd) ? cur_addr : 16'h0000;
        end else if (idx == IDX_FLD_STAT) begin
            rd_val[CAUSE_LO +: CAUSE_W] = cause_q;
        end else if (idx == IDX_PHY_STAT) begin
            rd_val[STAT_MDIX_BIT]  = mdix_s;
            rd_val[STAT_RXERR_BIT] = rx_latch_q;
            rd_val[STAT_POL_BIT]   = pol_q;
        end else if (idx == IDX_RX_ERR_CNT) begin
            rd_val = rx_cnt_q;
        end else if (idx == IDX_TENBASE) begin
            rd_val[TENBASE_POL_BIT] = pol_q;
        end
    end

    // Reads wait for captured data; writes are taken with no wait.
    always_comb begin
        state_d = state_q;
        case (state_q)
            PMAS_IDLE: begin
                if (mem_re) begin
                    state_d = PMAS_MEM_WAIT;
                end else if (READ) begin
                    state_d = PMAS_ACK;
                end
            end
            PMAS_MEM_WAIT: begin
                state_d = PMAS_ACK;
            end
            default: begin
                state_d = PMAS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            state_q <= PMAS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Capture at the issuing edge, the same edge that clears read-sensitive latches.
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            readdata_q <= 32'h0000_0000;
        end else if (rd_go) begin
            readdata_q <= {16'h0000, rd_val};
        end else if (state_q == PMAS_MEM_WAIT) begin
            readdata_q <= {16'h0000, mem_rdata};
        end
    end

    assign READDATA    = readdata_q;
    assign WAITREQUEST = READ & (state_q != PMAS_ACK);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    AST_DEVSEL_ROUTE: assert property (mem_we |->
        (devsel == DEVSEL_VENDOR && mem_addr[MMD_AW+1:MMD_AW] == SPACE_VENDOR)
        || (devsel == DEVSEL_MMD3 && mem_addr[MMD_AW+1:MMD_AW] == SPACE_MMD3)
        || (devsel == DEVSEL_MMD7 && mem_addr[MMD_AW+1:MMD_AW] == SPACE_MMD7))
        else $error("window write routed to the wrong space");
    AST_VENDOR_LIMIT: assert property ((wr_win && devsel == DEVSEL_VENDOR
        && cur_addr > VENDOR_MAX) |-> !mem_we)
        else $error("vendor write above top offset");
    AST_MMD3_SPACE: assert property ((mem_re && devsel == DEVSEL_MMD3) |->
        mem_addr[MMD_AW+1:MMD_AW] == SPACE_MMD3)
        else $error("MMD3 read routed elsewhere");
    AST_UNSUPPORTED_IGNORED: assert property ((wr_win && !supported) |=>
        $stable(mmd_addr_q[0]) && $stable(mmd_addr_q[1]) && $stable(mmd_addr_q[2]))
        else $error("unsupported device select changed an address");
    AST_ADDR_WRITE: assert property ((wr_win && supported && !data_cmd
        && BYTEENABLE[1:0] == 2'h3) |=> cur_addr == $past(wdat))
        else $error("address command did not load the address");
    AST_POST_INC: assert property ((wr_win && supported && cmd == CMD_DATA_INC_W)
        |=> cur_addr == $past(cur_addr) + 16'h0001)
        else $error("write did not advance the address");
    AST_NO_INC: assert property ((rd_win && supported && cmd == CMD_DATA_NOINC)
        |=> $stable(cur_addr))
        else $error("no-increment read moved the address");
    AST_CAUSE_LATCH: assert property (fire[CAUSE_W-1] |=> cause_q[CAUSE_W-1]
        ##1 (cause_q[CAUSE_W-1] || $past(clr_fld && !fire[CAUSE_W-1])))
        else $error("descrambler cause not latched");
    AST_LINK_DROP: assert property (|fire |=> LINK_DROP)
        else $error("enabled condition did not drop the link");
    AST_MDIX_READ: assert property ((rd_go && idx == IDX_PHY_STAT) |=>
        READDATA[STAT_MDIX_BIT] == $past(mdix_s))
        else $error("swap status misreported");
    AST_RXERR_CLEAR: assert property ((clr_rx && !rx_err_s) |=> !rx_latch_q)
        else $error("counter read left the error latch set");
    AST_POL_KEEP: assert property ((rd_go && idx == IDX_PHY_STAT && pol_q)
        |=> pol_q)
        else $error("status read cleared polarity");
    AST_FLD_CLEAR: assert property ((clr_fld && fire == '0) |=> cause_q == '0)
        else $error("cause bits survived a status read");
    AST_RSVD_ZERO: assert property ((rd_go && idx == IDX_FLD_STAT) |=>
        READDATA[31:CAUSE_LO+CAUSE_W] == '0 && READDATA[CAUSE_LO-1:0] == '0)
        else $error("reserved bits not zero");
    AST_READ_BOUND: assert property (rd_go |-> ##[1:2] !WAITREQUEST)
        else $error("read answer late");

    COV_WIN_READ: cover property (mem_re ##2 !WAITREQUEST);
    COV_INC_WRITE: cover property (wr_win && cmd == CMD_DATA_INC_RW && mem_we);
    COV_DROP: cover property (LINK_DROP ##[1:20] clr_fld);
    COV_RX_CLEAR: cover property (rx_latch_q ##1 clr_rx);

endmodule

// [pmas_host.sv]
// Management host model that issues Avalon-MM register cycles to the bank.
`timescale 1ns/1ps
module pmas_host (
    input  wire logic        CLOCK,
    input  wire logic        WAITREQUEST,
    output logic      [7:0]  ADDRESS,
    output logic             READ,
    output logic             WRITE,
    output logic      [31:0] WRITEDATA,
    output logic      [3:0]  BYTEENABLE
);
    // The bus idles at time zero so the block sees no stray request.
    initial begin
        ADDRESS    = 8'h00;
        READ       = 1'b0;
        WRITE      = 1'b0;
        WRITEDATA  = 32'h0000_0000;
        BYTEENABLE = 4'hf;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One cycle is held until waitrequest is seen low, then released for an idle clock.
    // The idle clock keeps the strobe from being assigned twice in one time step.
    // No cycle count is assumed; only the bench watchdog ends an answer that never comes.
    task automatic xfer(input logic rd, input logic [5:0] idx, input logic [15:0] d);
        ADDRESS   <= {idx, 2'b00};
        READ      <= rd;
        WRITE     <= ~rd;
        WRITEDATA <= {16'h0000, d};
        do begin
            @(posedge CLOCK);
        end while (WAITREQUEST !== 1'b0);
        READ  <= 1'b0;
        WRITE <= 1'b0;
        @(posedge CLOCK);
    endtask
endmodule

// [pmas_top_tb.sv]
// Self-checking testbench for the extended access and status register bank.
`timescale 1ns/1ps
module pmas_top_tb;
    import pmas_pkg::*;
    logic        CLOCK = 1'b0;
    logic        RESET_N = 1'b0;
    logic [4:0]  FLD_COND = 5'h00;
    logic        RX_ERR_EVT = 1'b0;
    logic        MDIX_SWAPPED = 1'b0;
    logic        POLARITY_INV = 1'b0;
    wire  [7:0]  ADDRESS;
    wire         READ, WRITE, WAITREQUEST, LINK_DROP;
    wire  [31:0] WRITEDATA, READDATA;
    wire  [3:0]  BYTEENABLE;
    int          err_total = 0;
    int          n_tests = 0;
    logic [31:0] exp_q[$];
    logic [15:0] a, d0;
    logic [15:0] d [3];
    logic [4:0]  sel [3] = '{5'h1f, 5'h03, 5'h07};

    // The clock toggles every half period of 2.5 ns.
    always #2.5 CLOCK = ~CLOCK;

    pmas_host host (.CLOCK(CLOCK), .WAITREQUEST(WAITREQUEST), .ADDRESS(ADDRESS), .READ(READ),
        .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE));
    pmas_top DUT (.CLOCK(CLOCK), .RESET_N(RESET_N), .ADDRESS(ADDRESS), .READ(READ),
        .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST), .FLD_COND(FLD_COND), .RX_ERR_EVT(RX_ERR_EVT),
        .MDIX_SWAPPED(MDIX_SWAPPED), .POLARITY_INV(POLARITY_INV), .LINK_DROP(LINK_DROP));

    ////////////////////////////////////////////////////////////////////////////////
    // Case equality keeps an unknown from passing as a match.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict in one place, reached by the main sequence or the watchdog.
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic rd(input logic [5:0] idx, input logic [15:0] e);
        exp_q.push_back({16'h0000, e});
        host.xfer(1'b1, idx, 16'h0000);
    endtask
    task automatic wr(input logic [5:0] idx, input logic [15:0] v);
        host.xfer(1'b0, idx, v);
    endtask
    task automatic setc(input logic [1:0] c, input logic [4:0] s);
        wr(IDX_ACC_CTRL, {c, 9'h000, s});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge CLOCK);
    endtask

    // Read data is taken at the answer edge and matched against the oldest note.
    always @(posedge CLOCK) begin
        if (READ === 1'b1 && WAITREQUEST === 1'b0 && exp_q.size() > 0) begin
            chk(READDATA, exp_q.pop_front());
        end
    end

    // A hang is cut short well beyond the few hundred cycles the tests need.
    initial begin
        idle(20000);
        err_total++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hdf30));
        a = 16'($urandom % 32'h400);
        d0 = 16'($urandom);
        for (int i = 0; i < 3; i++) d[i] = 16'($urandom) ^ {11'h000, sel[i]};
        idle(8);
        RESET_N <= 1'b1;
        idle(2);
        rd(IDX_ACC_CTRL, ACC_CTRL_RESET);
        rd(IDX_FLD_STAT, 16'h0000);
        rd(IDX_PHY_STAT, 16'h0000);
        rd(6'h3f, 16'h0000);
        wr(IDX_ACC_CTRL, 16'hffff);
        rd(IDX_ACC_CTRL, ACC_CTRL_MASK);
        $display("test reset and access control done");
        // Every supported select walks all four commands over the same offset.
        for (int i = 0; i < 3; i++) begin
            setc(CMD_ADDRESS, sel[i]);
            rd(IDX_WINDOW, WINDOW_RESET);
            wr(IDX_WINDOW, a);
            setc(CMD_DATA_NOINC, sel[i]);
            wr(IDX_WINDOW, d[i]);
            rd(IDX_WINDOW, d[i]);
            setc(CMD_DATA_INC_RW, sel[i]);
            rd(IDX_WINDOW, d[i]);
            wr(IDX_WINDOW, ~d[i]);
            setc(CMD_ADDRESS, sel[i]);
            rd(IDX_WINDOW, a + 16'h2);
            wr(IDX_WINDOW, a + 16'h1);
            setc(CMD_DATA_INC_W, sel[i]);
            rd(IDX_WINDOW, ~d[i]);
            rd(IDX_WINDOW, ~d[i]);
            wr(IDX_WINDOW, d[i]);
            setc(CMD_ADDRESS, sel[i]);
            rd(IDX_WINDOW, a + 16'h2);
        end
        // Each select must reach its own space, so the same offset holds distinct data.
        for (int i = 0; i < 3; i++) begin
            setc(CMD_ADDRESS, sel[i]);
            wr(IDX_WINDOW, a);
            setc(CMD_DATA_NOINC, sel[i]);
            rd(IDX_WINDOW, d[i]);
        end
        setc(CMD_DATA_NOINC, 5'h02);
        rd(IDX_WINDOW, 16'h0000);
        wr(IDX_WINDOW, 16'h1234);
        setc(CMD_ADDRESS, DEVSEL_VENDOR);
        rd(IDX_WINDOW, a);
        wr(IDX_WINDOW, VENDOR_MAX);
        setc(CMD_DATA_NOINC, DEVSEL_VENDOR);
        wr(IDX_WINDOW, d0);
        rd(IDX_WINDOW, d0);
        setc(CMD_ADDRESS, DEVSEL_VENDOR);
        wr(IDX_WINDOW, VENDOR_MAX + 16'h1);
        setc(CMD_DATA_INC_RW, DEVSEL_VENDOR);
        wr(IDX_WINDOW, 16'h5a5a);
        rd(IDX_WINDOW, 16'h0000);
        setc(CMD_ADDRESS, DEVSEL_VENDOR);
        rd(IDX_WINDOW, VENDOR_MAX + 16'h3);
        $display("test window access done");
        // Each cause alone drops the link and latches only its own bit.
        wr(IDX_FLD_MODE, FLD_MODE_MASK);
        for (int i = 0; i < 5; i++) begin
            FLD_COND <= 5'(1 << i);
            idle(5);
            chk({31'h0, LINK_DROP}, 32'h1);
            FLD_COND <= 5'h00;
            idle(5);
            rd(IDX_FLD_STAT, 16'(1 << (i + 4)));
            rd(IDX_FLD_STAT, 16'h0000);
        end
        wr(IDX_FLD_MODE, 16'h0002);
        FLD_COND <= 5'h1f;
        idle(5);
        chk({31'h0, LINK_DROP}, 32'h1);
        FLD_COND <= 5'h1d;
        idle(5);
        chk({31'h0, LINK_DROP}, 32'h0);
        FLD_COND <= 5'h00;
        rd(IDX_FLD_STAT, 16'h0020);
        $display("test link drop causes done");
        // Latches in the status summary clear only through their own source registers.
        MDIX_SWAPPED <= 1'b1;
        RX_ERR_EVT <= 1'b1;
        idle(2);
        RX_ERR_EVT <= 1'b0;
        idle(5);
        rd(IDX_PHY_STAT, 16'h6000);
        rd(IDX_PHY_STAT, 16'h6000);
        rd(IDX_RX_ERR_CNT, 16'h0001);
        rd(IDX_PHY_STAT, 16'h4000);
        POLARITY_INV <= 1'b1;
        idle(3);
        POLARITY_INV <= 1'b0;
        MDIX_SWAPPED <= 1'b0;
        idle(5);
        rd(IDX_PHY_STAT, 16'h1000);
        rd(IDX_PHY_STAT, 16'h1000);
        rd(IDX_TENBASE, 16'h0010);
        rd(IDX_PHY_STAT, 16'h0000);
        idle(4);
        $display("test status summary done");
        test_done();
    end
endmodule
